// ### core/isc_pkg.sv
// constants for the sample clock selector of an inertial measurement unit
// assumes a single 125 MHz system clock and a host-side register writer
package isc_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int INT_RATE_HZ = 2000;
  localparam int INT_DIV = CLK_HZ / INT_RATE_HZ;
  localparam int LOCK_TOL_US = 100;
  localparam int LOCK_TOL_CYC = LOCK_TOL_US * (CLK_HZ / 1000000);
  localparam int CTL_LAG_US = 200;
  localparam int CTL_LAG_CYC = CTL_LAG_US * (CLK_HZ / 1000000);
  localparam int EXT_CYCLES_NEEDED = 2;
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 3;
  localparam int CAL_LSB = 6;
  localparam int CAL_MSB = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] FACTOR_RESET = 16'h07d0;
  localparam int PERIOD_W = 32;
  localparam int PULSE_CYC = 8;
  typedef enum logic [1:0] {
    ISC_INTERNAL = 2'b00,
    ISC_DIRECT   = 2'b01,
    ISC_SCALED   = 2'b10,
    ISC_OUTSYNC  = 2'b11
  } isc_mode_e;
endpackage

// ### core/isc_scaled_loop.sv
// digital frequency multiplier locked to a slow reference edge
// assumes refEdge is a synchronised one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none
module isc_scaled_loop (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         restart,
  input  wire logic                         refEdge,
  input  wire logic [15:0]                  factor,
  output logic                              tick,
  output logic                              locked
);
  import isc_pkg::*;

  logic [PERIOD_W-1:0] refCount, next_refCount;
  logic [PERIOD_W-1:0] step, next_step;
  logic [PERIOD_W-1:0] phase, next_phase;
  logic [15:0]         ticksLeft, next_ticksLeft;
  logic                seenRef, next_seenRef;
  logic                next_tick, next_locked;

  always_comb begin
    next_refCount = refCount + 1'b1;
    next_step = step;
    next_phase = phase;
    next_ticksLeft = ticksLeft;
    next_seenRef = seenRef;
    next_tick = 1'b0;
    next_locked = locked;
    if (restart) begin
      next_refCount = '0;
      next_step = '0;
      next_phase = '0;
      next_ticksLeft = '0;
      next_seenRef = 1'b0;
      next_locked = 1'b0;
    end else if (refEdge) begin
      // reference edge realigns the feedback edge
      next_refCount = '0;
      next_seenRef = 1'b1;
      if (seenRef && factor != 16'h0000) begin
        next_step = refCount / PERIOD_W'(factor);
      end
      if (seenRef && step != '0) begin
        if (phase <= PERIOD_W'(LOCK_TOL_CYC) ||
            step - phase <= PERIOD_W'(LOCK_TOL_CYC)) begin
          next_locked = 1'b1;
        end
      end
      next_phase = '0;
      next_ticksLeft = factor;
      if (step != '0 && factor != 16'h0000) begin
        next_tick = 1'b1;
        next_ticksLeft = factor - 16'h0001;
      end
    end else if (step != '0) begin
      if (phase + 1'b1 >= step) begin
        next_phase = '0;
        if (ticksLeft != 16'h0000) begin
          next_tick = 1'b1;
          next_ticksLeft = ticksLeft - 16'h0001;
        end
      end else begin
        next_phase = phase + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refCount <= '0;
      step <= '0;
      phase <= '0;
      ticksLeft <= '0;
      seenRef <= 1'b0;
      tick <= 1'b0;
      locked <= 1'b0;
    end else begin
      refCount <= next_refCount;
      step <= next_step;
      phase <= next_phase;
      ticksLeft <= next_ticksLeft;
      seenRef <= next_seenRef;
      tick <= next_tick;
      locked <= next_locked;
    end
  end
endmodule
`default_nettype wire

// ### core/isc_sample_clock_select.sv
// sample clock source selection and readback staging
// assumes control writes arrive as one-cycle strobes on clk
`timescale 1ns/1ps
`default_nettype none
module isc_sample_clock_select #(
  parameter int INT_DIV_P  = isc_pkg::INT_DIV,
  parameter int CTL_LAG_P  = isc_pkg::CTL_LAG_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         ctrlWrite,
  input  wire logic [15:0]                  ctrlData,
  input  wire logic                         factorWrite,
  input  wire logic [15:0]                  factorData,
  input  wire logic                         syncIn,
  output logic                              syncOut,
  output logic                              syncOe,
  output logic                              sampleTick,
  output logic                              sample_update_pin,
  output logic [15:0]                       misc_control_reg,
  output logic [15:0]                       clock_multiplier_factor,
  output logic                              pllLocked
);
  import isc_pkg::*;

  // ****************************************************************
  // pin synchroniser and edge detect
  // ****************************************************************
  logic syncMeta, syncStable, syncLast;
  logic next_syncMeta, next_syncStable, next_syncLast;
  logic syncRise;

  // two flops guard against a metastable pin level
  always_comb begin
    next_syncMeta = syncIn;
    next_syncStable = syncMeta;
    next_syncLast = syncStable;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncMeta <= 1'b0;
      syncStable <= 1'b0;
      syncLast <= 1'b0;
    end else begin
      syncMeta <= next_syncMeta;
      syncStable <= next_syncStable;
      syncLast <= next_syncLast;
    end
  end
  // a rise is seen one to two cycles after the pin moves
  assign syncRise = syncStable & ~syncLast;

  // ****************************************************************
  // mode and factor staging
  // ****************************************************************
  // modes that wait for the reference before they take over
  function automatic logic isExtMode(input logic [1:0] mode);
    return (mode == ISC_DIRECT) || (mode == ISC_SCALED);
  endfunction

  logic [15:0] factorShadow, next_factorShadow;
  logic [1:0]  activeMode, next_activeMode;
  logic [1:0]  pendMode, next_pendMode;
  logic        pending, next_pending;
  logic [1:0]  extSeen, next_extSeen;
  logic        factorRestart;
  logic        modeApply;

  always_comb begin
    next_factorShadow = factorShadow;
    next_activeMode = activeMode;
    next_pendMode = pendMode;
    next_pending = pending;
    next_extSeen = extSeen;
    factorRestart = 1'b0;
    modeApply = 1'b0;
    // a new factor reruns staging, so in direct and scaled mode its readback waits for the reference
    if (factorWrite && factorData != factorShadow) begin
      next_factorShadow = factorData;
      factorRestart = 1'b1;
      next_pending = 1'b1;
      next_pendMode = pending ? pendMode : activeMode;
      next_extSeen = 2'b00;
    end
    // the newest mode write replaces any staged one
    if (ctrlWrite && (pending || ctrlData[MODE_MSB:MODE_LSB] != activeMode))
    begin
      next_pendMode = ctrlData[MODE_MSB:MODE_LSB];
      next_pending = 1'b1;
      next_extSeen = 2'b00;
    end
    if (pending && !ctrlWrite && !factorWrite) begin
      // external modes need the reference seen twice
      if (isExtMode(pendMode)) begin
        if (syncRise && extSeen != 2'(EXT_CYCLES_NEEDED)) begin
          next_extSeen = extSeen + 2'b01;
        end
        if (extSeen == 2'(EXT_CYCLES_NEEDED)) begin
          next_pending = 1'b0;
        end
      end else begin
        next_pending = 1'b0;
      end
      if (!next_pending) begin
        modeApply = 1'b1;
        next_activeMode = pendMode;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      factorShadow <= FACTOR_RESET;
      activeMode <= ISC_INTERNAL;
      pendMode <= ISC_INTERNAL;
      pending <= 1'b0;
      extSeen <= 2'b00;
    end else begin
      factorShadow <= next_factorShadow;
      activeMode <= next_activeMode;
      pendMode <= next_pendMode;
      pending <= next_pending;
      extSeen <= next_extSeen;
    end
  end

  // ****************************************************************
  // calibration option lag
  // ****************************************************************
  logic [3:0]  calPend, next_calPend;
  logic        calBusy, next_calBusy;
  logic [31:0] lagCount, next_lagCount;
  logic        calApply;

  always_comb begin
    next_calPend = calPend;
    next_calBusy = calBusy;
    next_lagCount = lagCount;
    calApply = 1'b0;
    if (ctrlWrite) begin
      // the newest write wins, a write of the shown value cancels
      next_calPend = ctrlData[CAL_MSB:CAL_LSB];
      next_calBusy = (ctrlData[CAL_MSB:CAL_LSB] !=
                      misc_control_reg[CAL_MSB:CAL_LSB]);
      next_lagCount = 32'(CTL_LAG_P - 1);
    end else if (calBusy) begin
      if (lagCount == 32'h0) begin
        next_calBusy = 1'b0;
        calApply = 1'b1;
      end else begin
        next_lagCount = lagCount - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      calPend <= 4'h0;
      calBusy <= 1'b0;
      lagCount <= 32'h0;
    end else begin
      calPend <= next_calPend;
      calBusy <= next_calBusy;
      lagCount <= next_lagCount;
    end
  end

  // ****************************************************************
  // readback registers
  // ****************************************************************
  logic [15:0] next_misc, next_factorRead;
  logic        factorApplied, next_factorApplied;

  always_comb begin
    next_misc = misc_control_reg;
    next_factorRead = clock_multiplier_factor;
    next_factorApplied = modeApply;
    if (ctrlWrite) begin
      // mode and option bits keep their old value until applied
      next_misc = {ctrlData[15:CAL_MSB+1],
                   misc_control_reg[CAL_MSB:CAL_LSB],
                   ctrlData[CAL_LSB-1:MODE_MSB+1],
                   misc_control_reg[MODE_MSB:MODE_LSB],
                   ctrlData[MODE_LSB-1:0]};
    end
    if (calApply) begin
      next_misc[CAL_MSB:CAL_LSB] = calPend;
    end
    if (modeApply) begin
      next_misc[MODE_MSB:MODE_LSB] = pendMode;
      next_factorRead = factorShadow;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_control_reg <= CTRL_RESET;
      clock_multiplier_factor <= FACTOR_RESET;
      factorApplied <= 1'b0;
    end else begin
      misc_control_reg <= next_misc;
      clock_multiplier_factor <= next_factorRead;
      factorApplied <= next_factorApplied;
    end
  end

  // ****************************************************************
  // internal oscillator and multiplier
  // ****************************************************************
  // free running, so internal ticks keep their phase across mode changes
  logic [31:0] intCount, next_intCount;
  logic        intTick;
  always_comb begin
    next_intCount = intCount + 32'h1;
    if (intCount >= 32'(INT_DIV_P - 1)) begin
      next_intCount = 32'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intCount <= 32'h0;
    end else begin
      intCount <= next_intCount;
    end
  end
  assign intTick = (intCount == 32'(INT_DIV_P - 1));

  // the loop restarts only when the staged factor really changes
  logic loopTick, loopLocked;
  isc_scaled_loop u_loop (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (factorRestart),
    .refEdge (syncRise),
    .factor  (factorShadow),
    .tick    (loopTick),
    .locked  (loopLocked)
  );

  // ****************************************************************
  // source select and sync pulse
  // ****************************************************************
  logic       rawTick;
  logic [3:0] pulseLeft, next_pulseLeft;

  always_comb begin
    unique case (activeMode)
      ISC_INTERNAL: rawTick = intTick;
      ISC_DIRECT:   rawTick = syncRise;
      ISC_SCALED:   rawTick = loopTick;
      ISC_OUTSYNC:  rawTick = intTick;
    endcase
    next_pulseLeft = pulseLeft;
    if (rawTick) begin
      next_pulseLeft = 4'(PULSE_CYC);
    end else if (pulseLeft != 4'h0) begin
      next_pulseLeft = pulseLeft - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseLeft <= 4'h0;
    end else begin
      pulseLeft <= next_pulseLeft;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic next_syncOut, next_syncOe, next_update, next_pllLocked;

  always_comb begin
    // the pin is driven only while the pulse mode is active
    next_syncOe = (activeMode == ISC_OUTSYNC);
    next_syncOut = next_syncOe && (next_pulseLeft != 4'h0);
    // data ready toggles on each sample so the host sees completion
    next_update = sample_update_pin ^ rawTick;
    // lock reads low for one cycle, the cycle after any staged mode or factor takes over in readback
    next_pllLocked = loopLocked & ~factorApplied;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncOut <= 1'b0;
      syncOe <= 1'b0;
      sampleTick <= 1'b0;
      sample_update_pin <= 1'b0;
      pllLocked <= 1'b0;
    end else begin
      syncOut <= next_syncOut;
      syncOe <= next_syncOe;
      sampleTick <= rawTick;
      sample_update_pin <= next_update;
      pllLocked <= next_pllLocked;
    end
  end
endmodule
`default_nettype wire

// ### verif/isc_sample_clock_select_checker.sv
// port assertions for the sample clock selector
// assumes one clock domain reset by rst_b
`timescale 1ns/1ps
`default_nettype none
module isc_sample_clock_select_checker
  import isc_pkg::*;
#(
  parameter int INT_DIV_P = 50,
  parameter int CTL_LAG_P = 20
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ctrlWrite,
  input wire logic [15:0] ctrlData,
  input wire logic        factorWrite,
  input wire logic [15:0] factorData,
  input wire logic        syncIn,
  input wire logic        syncOut,
  input wire logic        syncOe,
  input wire logic        sampleTick,
  input wire logic        sample_update_pin,
  input wire logic [15:0] misc_control_reg,
  input wire logic [15:0] clock_multiplier_factor,
  input wire logic        pllLocked
);
  int gap;
  int seen;
  int sinceWr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // tick spacing, ticks since last write, cycles since control write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 0;
      seen <= 0;
      sinceWr <= 0;
    end else begin
      gap <= sampleTick ? 1 : gap + 1;
      seen <= (ctrlWrite || factorWrite) ? 0 :
              (sampleTick && seen < 3) ? seen + 1 : seen;
      sinceWr <= ctrlWrite ? 0 : sinceWr + 1;
    end
  end
  a_tick_single: assert property (sampleTick |=> !sampleTick)
    else $error("sample tick wider than one cycle");
  a_ready_toggle: assert property (
    sampleTick |-> ##[0:1] $changed(sample_update_pin))
    else $error("data ready did not toggle");
  a_int_period: assert property (
    sampleTick && seen == 3 && misc_control_reg[3] == misc_control_reg[2]
    |-> gap == INT_DIV_P) else $error("internal sample period wrong");
  a_pulse_width: assert property (
    $rose(syncOut) |-> syncOut[*8] ##1 !syncOut)
    else $error("sync output pulse width wrong");
  a_reset_default: assert property ($rose(rst_b) |->
    misc_control_reg == CTRL_RESET && clock_multiplier_factor == FACTOR_RESET)
    else $error("reset readback wrong");
  a_low_bits_echo: assert property (ctrlWrite |=>
    (misc_control_reg & 16'hfc33) == ($past(ctrlData) & 16'hfc33))
    else $error("plain control bits not echoed");
  a_cal_window: assert property ($changed(misc_control_reg[9:6])
    |-> sinceWr >= 2 && sinceWr <= CTL_LAG_P + 1)
    else $error("option bits updated outside window");
  a_relock_start: assert property (factorWrite && pllLocked &&
    factorData != clock_multiplier_factor |-> ##[1:3] !pllLocked)
    else $error("lock kept after factor change");
  c_relock: cover property ($fell(pllLocked));
  c_sync_pulse: cover property ($rose(syncOut));
  c_direct: cover property (sampleTick && misc_control_reg[3:2] == 2'b01);
endmodule
bind isc_sample_clock_select isc_sample_clock_select_checker #(
  .INT_DIV_P(INT_DIV_P), .CTL_LAG_P(CTL_LAG_P)) u_chk (
  .clk(clk), .rst_b(rst_b), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
  .factorWrite(factorWrite), .factorData(factorData), .syncIn(syncIn),
  .syncOut(syncOut), .syncOe(syncOe), .sampleTick(sampleTick),
  .sample_update_pin(sample_update_pin), .misc_control_reg(misc_control_reg),
  .clock_multiplier_factor(clock_multiplier_factor), .pllLocked(pllLocked));
`default_nettype wire

// ### verif/isc_sync_source.sv
// external timing reference model for the timing pin
// assumes the bench resolves the pin when the device drives it
`timescale 1ns/1ps
`default_nettype none
module isc_sync_source (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] half,
  output logic             refLevel
);
  logic [15:0] cnt;
  initial refLevel = 1'b0;
  initial cnt = 16'h0000;
  // steady square wave, present for many cycles
  // when stopped the reference rests low
  always @(posedge clk) begin
    if (!run) begin
      refLevel <= 1'b0;
      cnt <= 16'h0000;
    end else if (cnt >= half - 16'h0001) begin
      refLevel <= ~refLevel;
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### verif/isc_sample_clock_select_tb.sv
// self-checking bench for the sample clock selector
// assumes the checker is bound in and the reference model compiled
`timescale 1ns/1ps
`default_nettype none
module isc_sample_clock_select_tb;
  import isc_pkg::*;
  localparam int DIV = 50;
  localparam int LAG = 20;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ctrlWrite = 1'b0;
  logic        factorWrite = 1'b0;
  logic [15:0] wrData = 16'h0000;
  logic        refRun = 1'b0;
  logic [15:0] refHalf = 16'h0019;
  logic [15:0] c;
  logic [15:0] tg;
  wire logic   refLevel, syncOut, syncOe, sampleTick, locked, pin, ready;
  wire logic [15:0] ctl, fac;
  int          failures = 0;
  int          cmpCount = 0;
  int          cyc = 0;
  assign pin = syncOe ? syncOut : refLevel;
  always #4 clk = ~clk;
  isc_sample_clock_select #(.INT_DIV_P(DIV), .CTL_LAG_P(LAG))
    u_isc_sample_clock_select (
    .clk(clk), .rst_b(rst_b), .ctrlWrite(ctrlWrite), .ctrlData(wrData),
    .factorWrite(factorWrite), .factorData(wrData), .syncIn(pin),
    .syncOut(syncOut), .syncOe(syncOe), .sampleTick(sampleTick),
    .sample_update_pin(ready), .misc_control_reg(ctl),
    .clock_multiplier_factor(fac), .pllLocked(locked));
  isc_sync_source u_src (.clk(clk), .run(refRun), .half(refHalf),
    .refLevel(refLevel));
  task automatic summarize;
    $display("checks %0d failures %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input int lo, input int hi);
    cmpCount++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, lo[15:0]);
    end
  endtask
  task automatic wr(input logic isCtl, input logic [15:0] d);
    @(negedge clk);
    ctrlWrite = isCtl;
    factorWrite = !isCtl;
    wrData = d;
    @(negedge clk);
    ctrlWrite = 1'b0;
    factorWrite = 1'b0;
  endtask
  task automatic cnt(input int n, input logic useOut);
    logic last;
    logic lastReady;
    c = 16'h0000;
    tg = 16'h0000;
    last = syncOut;
    lastReady = ready;
    repeat (n) begin
      @(negedge clk);
      if (useOut ? (syncOut && !last) : sampleTick)
        c++;
      if (ready !== lastReady)
        tg++;
      last = syncOut;
      lastReady = ready;
    end
  endtask
  task automatic settle(input logic [1:0] m, input logic lk);
    int k;
    k = 0;
    while ((ctl[3:2] !== m || (lk && locked !== 1'b1)) && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk({14'h0000, ctl[3:2]}, m, m);
  endtask
  task automatic t_reset;
    chk(ctl, 0, 0);
    chk(fac, 16'h07d0, 16'h07d0);
    cnt(DIV * 10, 1'b0);
    chk(c, 10, 10);
    chk(tg, 10, 10);
  endtask
  task automatic t_ctrl;
    wr(1'b1, 16'h0000);
    wr(1'b1, 16'hf3f3);
    chk({12'h000, ctl[9:6]}, 0, 0);
    chk(ctl & 16'hfc33, 16'hf033, 16'hf033);
    repeat (LAG + 2) @(negedge clk);
    chk({12'h000, ctl[9:6]}, 15, 15);
  endtask
  task automatic t_direct;
    refRun = 1'b1;
    repeat (120) @(negedge clk);
    wr(1'b1, 16'h0004);
    chk({14'h0000, ctl[3:2]}, 0, 0);
    settle(2'b01, 1'b0);
    cnt(500, 1'b0);
    chk(c, 10, 10);
  endtask
  task automatic t_scaled;
    refHalf = 16'd200;
    wr(1'b0, 16'h0008);
    wr(1'b1, 16'h0008);
    settle(2'b10, 1'b1);
    chk(fac, 8, 8);
    cnt(1600, 1'b0);
    chk(c, 31, 33);
    wr(1'b0, 16'h0010);
    repeat (4) @(negedge clk);
    chk({15'h0000, locked}, 0, 0);
    settle(2'b10, 1'b1);
    chk(fac, 16, 16);
    cnt(1600, 1'b0);
    chk(c, 63, 65);
  endtask
  task automatic t_outsync;
    refRun = 1'b0;
    wr(1'b1, 16'h000c);
    settle(2'b11, 1'b0);
    repeat (2) @(negedge clk);
    chk({15'h0000, syncOe}, 1, 1);
    cnt(500, 1'b1);
    chk(c, 10, 10);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_ctrl();
    t_direct();
    t_scaled();
    t_outsync();
    summarize();
  end
endmodule
`default_nettype wire
